/* File: include/synth_ctl_regs.vh */
// Purpose: constants for the synthesizer power and lock-detect control
// Assumes: 100 MHz core_clk (10 ns period)
// Notes:   phase error arrives as a count of core_clk-scale ns per compare edge
`ifndef SYNTH_CTL_REGS_VH
`define SYNTH_CTL_REGS_VH
`define CLK_PERIOD_NS        10
`define LOCK_CYCLES          3'h5
`define MAIN_ENTRY_NS        8'h0A
`define MAIN_EXIT_NS         8'h14
`define AUX_ENTRY_NS         8'h0F
`define AUX_EXIT_NS          8'h1E
`define PRESCALE_DIV         2'h3
`define CP_STEP_W            4
`define MUX_LOCK_MAIN        4'h2
`define MUX_LOCK_AUX         4'h3
`define MUX_LOCK_BOTH        4'h4
`define CSR_FACTOR_W         2
`endif

/* File: rtl/lock_window.v */
// Purpose: one loop's digital lock detector with hysteresis
// Assumes: sampleEn pulses once per (prescaled) compare cycle
// Notes:   phaseErrNs is a measured error in ns; windows are parameters
`timescale 1ns/10ps
`include "synth_ctl_regs.vh"
module lock_window #(
   parameter [7:0] ENTRY_NS = 8'h0A,
   parameter [7:0] EXIT_NS  = 8'h14
) (
   input  wire       core_clk,
   input  wire       srst,
   input  wire       clear,
   input  wire       sampleEn,
   input  wire [7:0] phaseErrNs,
   output reg        locked_r
);
   reg [2:0] goodCnt_r;

   always @(posedge core_clk) begin
      if (srst || clear) begin
         goodCnt_r <= 3'h0;
         locked_r  <= 1'b0;
      end else if (sampleEn) begin
         if (locked_r) begin
            if (phaseErrNs > EXIT_NS) begin // [RULE6]
               locked_r  <= 1'b0;
               goodCnt_r <= 3'h0;
            end
         end else if (phaseErrNs < ENTRY_NS) begin
            if (goodCnt_r == `LOCK_CYCLES - 3'h1) begin // [RULE5]
               locked_r <= 1'b1;
            end else begin
               goodCnt_r <= goodCnt_r + 3'h1;
            end
         end else begin
            goodCnt_r <= 3'h0; // [RULE18]
         end
      end
   end
endmodule // lock_window

/* File: rtl/synth_power_lock_detect.v */
// Purpose: power-state decision, lock detect and acquisition-mode timing
// Assumes: core_clk is the comparison clock; compEdge marks one compare cycle
// Notes:   chip enable pin is asynchronous to the logic, so it gates outputs directly
// How it works
// RULE1 - chip enable low powers everything down at once, overriding all bits
// RULE2 - enable high and both power-down bits clear: fully powered up
// RULE3 - either power-down bit alone powers down only its loop, asynchronously
// RULE4 - auto power-up plus main divider write powers main loop up anyway
// RULE5 - locked after phase error below entry window five consecutive cycles
// RULE6 - once locked, unlock only when error exceeds wider exit window
// RULE7 - main loop windows 10/20 ns, auxiliary loop 15/30 ns
// RULE8 - powered-down loop forces lock output low when lock is selected
// RULE9 - prescale bit divides compare clock to detector by four
// RULE10 - combined lock selection shows low when either loop is unlocked
// RULE11 - slip reduction lowers comparison rate during acquisition only
// RULE12 - fast acquisition raises pump current and switches parallel resistor
// RULE13 - timeout counter engages and releases acquisition modes automatically
// RULE14 - host keeps steady pump current at 8X or 4X or less
// RULE15 - host does not enable slip reduction and fast acquisition together
// RULE16 - host sets slip-reduction end near transient peak time
// RULE17 - main pump current has sixteen steps, auxiliary current fixed
// RULE18 - before lock, any out-of-window cycle restarts the count
`timescale 1ns/10ps
`include "synth_ctl_regs.vh"
module synth_power_lock_detect (
   input  wire                     core_clk,
   input  wire                     srst,
   input  wire                     chipEnable,
   input  wire                     main_loop_powerdown,
   input  wire                     aux_loop_powerdown,
   input  wire                     auto_powerup_on_divider_write,
   input  wire                     mainDividerWrite,
   input  wire                     lock_detect_prescale_quarter,
   input  wire [3:0]               test_output_select,
   input  wire                     compEdge,
   input  wire [7:0]               mainPhaseErrNs,
   input  wire [7:0]               auxPhaseErrNs,
   input  wire                     slip_reduction,
   input  wire                     fastAcqEnable,
   input  wire [15:0]              acqTimeout,
   input  wire [`CP_STEP_W-1:0]    mainPumpSteady,
   input  wire [`CP_STEP_W-1:0]    mainPumpFast,
   input  wire [`CSR_FACTOR_W-1:0] slipFactor,
   output wire                     mainPowered,
   output wire                     auxPowered,
   output wire                     mainLocked,
   output wire                     auxLocked,
   output wire                     test_lock_output,
   output reg  [`CP_STEP_W-1:0]    mainPumpCurrent_r,
   output reg                      parallelResistorOn_r,
   output reg                      compEnable_r,
   output reg                      acqActive_r
);
   reg        ceMeta_r, ceSync2_r, ceSync3_r, ceStable_r;
   reg        mainPuOverride_r;
   reg  [1:0] preCnt_r;
   reg  [15:0] acqCnt_r;
   reg  [3:0] slipCnt_r;
   reg        mainLock_r, auxLock_r;
   wire       detEn;
   wire       mainLd, auxLd;
   reg  [3:0] slipDiv;
   reg        muxOut;

   // enable pin is asynchronous; synchronised copy drives only the override, raw pin still clears lock and acquisition state
   always @(posedge core_clk) begin
      if (srst) begin
         ceMeta_r   <= 1'b0;
         ceSync2_r  <= 1'b0;
         ceSync3_r  <= 1'b0;
         ceStable_r <= 1'b0;
      end else begin
         ceMeta_r  <= chipEnable;
         ceSync2_r <= ceMeta_r;
         ceSync3_r <= ceSync2_r;
         // a level change is taken only once the last two stages agree
         if (ceSync2_r == ceSync3_r) begin
            ceStable_r <= ceSync2_r;
         end
      end
   end

   // divider write latches the override until the power-down bit is rewritten low
   always @(posedge core_clk) begin
      if (srst || !ceStable_r) begin
         mainPuOverride_r <= 1'b0;
      end else if (mainDividerWrite && auto_powerup_on_divider_write) begin
         mainPuOverride_r <= 1'b1; // [RULE4]
      end else if (!main_loop_powerdown) begin
         mainPuOverride_r <= 1'b0;
      end
   end

   // power states are combinational so power-down is immediate
   assign mainPowered = chipEnable &
      (~main_loop_powerdown | mainPuOverride_r |
       (mainDividerWrite & auto_powerup_on_divider_write)); // [RULE1] [RULE2] [RULE3] [RULE4]
   assign auxPowered = chipEnable & ~aux_loop_powerdown; // [RULE1] [RULE2] [RULE3]

   always @(posedge core_clk) begin
      if (srst) begin
         preCnt_r <= 2'h0;
      end else if (compEdge) begin
         preCnt_r <= preCnt_r + 2'h1;
      end
   end
   // quarter-rate sampling trades response time for accuracy at high rates
   assign detEn = compEdge &
      (~lock_detect_prescale_quarter | (preCnt_r == `PRESCALE_DIV)); // [RULE9]

   lock_window #(
      .ENTRY_NS (`MAIN_ENTRY_NS),
      .EXIT_NS  (`MAIN_EXIT_NS)
   ) mainDet ( // [RULE7]
      .core_clk   (core_clk),
      .srst       (srst),
      .clear      (~mainPowered),
      .sampleEn   (detEn),
      .phaseErrNs (mainPhaseErrNs),
      .locked_r   (mainLd)
   );

   lock_window #(
      .ENTRY_NS (`AUX_ENTRY_NS),
      .EXIT_NS  (`AUX_EXIT_NS)
   ) auxDet ( // [RULE7]
      .core_clk   (core_clk),
      .srst       (srst),
      .clear      (~auxPowered),
      .sampleEn   (detEn),
      .phaseErrNs (auxPhaseErrNs),
      .locked_r   (auxLd)
   );

   assign mainLocked = mainLd & mainPowered; // [RULE8]
   assign auxLocked  = auxLd & auxPowered; // [RULE8]

   always @* begin
      case (test_output_select)
         `MUX_LOCK_MAIN: muxOut = mainLocked; // [RULE8]
         `MUX_LOCK_AUX:  muxOut = auxLocked; // [RULE8]
         `MUX_LOCK_BOTH: muxOut = mainLocked & auxLocked; // [RULE10]
         default:        muxOut = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (srst) begin
         mainLock_r <= 1'b0;
         auxLock_r  <= 1'b0;
      end else begin
         mainLock_r <= muxOut;
         auxLock_r  <= muxOut;
      end
   end
   // forced low at once when the chip enable drops
   assign test_lock_output = mainLock_r & auxLock_r & chipEnable; // [RULE1]

   // acquisition timer started by a divider write, released by the count
   always @(posedge core_clk) begin
      if (srst || !mainPowered) begin
         acqCnt_r    <= 16'h0000;
         acqActive_r <= 1'b0;
      end else if (mainDividerWrite && (slip_reduction || fastAcqEnable)) begin
         acqCnt_r    <= acqTimeout; // [RULE13]
         acqActive_r <= (acqTimeout != 16'h0000);
      end else if (acqActive_r && compEdge) begin
         if (acqCnt_r == 16'h0001) begin
            acqActive_r <= 1'b0; // [RULE13]
         end
         acqCnt_r <= acqCnt_r - 16'h0001;
      end
   end

   always @* begin
      case (slipFactor)
         2'h1:    slipDiv = 4'h1;
         2'h2:    slipDiv = 4'h3;
         2'h3:    slipDiv = 4'hF;
         default: slipDiv = 4'h0;
      endcase
   end

   // slip reduction passes one compare edge in 2, 4 or 16
   always @(posedge core_clk) begin
      if (srst) begin
         slipCnt_r    <= 4'h0;
         compEnable_r <= 1'b0;
      end else begin
         compEnable_r <= 1'b0;
         if (compEdge) begin
            if (acqActive_r && slip_reduction && (slipCnt_r != slipDiv)) begin
               slipCnt_r <= slipCnt_r + 4'h1; // [RULE11]
            end else begin
               slipCnt_r    <= 4'h0;
               compEnable_r <= 1'b1;
            end
         end
      end
   end

   // auxiliary pump current is fixed, so only the main loop is selectable
   always @(posedge core_clk) begin
      if (srst) begin
         mainPumpCurrent_r    <= {`CP_STEP_W{1'b0}};
         parallelResistorOn_r <= 1'b0;
      end else if (acqActive_r && (fastAcqEnable || slip_reduction)) begin
         mainPumpCurrent_r    <= mainPumpFast; // [RULE17] [RULE12] [RULE11]
         parallelResistorOn_r <= fastAcqEnable; // [RULE12]
      end else begin
         mainPumpCurrent_r    <= mainPumpSteady; // [RULE17]
         parallelResistorOn_r <= 1'b0;
      end
   end
endmodule // synth_power_lock_detect

/* File: sim/host_model.sv */
// Purpose: host settings for the acquisition modes
// Assumes: mode 1/3/4 slip reduction at 1/2, 1/4, 1/16; mode 2 fast acquisition
// Notes:   pump step n stands for (n+1)X
`timescale 1ns/10ps
`include "synth_ctl_regs.vh"
module host_model (
   input  wire [2:0]               mode,
   output wire                     slip_reduction,
   output wire                     fastAcqEnable,
   output wire [15:0]              acqTimeout,
   output wire [`CP_STEP_W-1:0]    mainPumpSteady,
   output wire [`CP_STEP_W-1:0]    mainPumpFast,
   output wire [`CSR_FACTOR_W-1:0] slipFactor
);
   // never both: slip reduction has to end far earlier than fast acquisition
   assign slip_reduction = (mode == 3'h1) || (mode == 3'h3) || (mode == 3'h4);
   assign fastAcqEnable  = (mode == 3'h2);
   // slip ends early, near the transient peak
   assign acqTimeout     = slip_reduction ? 16'h0028 : 16'h003C;
   // steady 8X, 4X, 1X against 16X fast keeps the ratio equal to each factor
   assign mainPumpSteady = (mode == 3'h1) ? 4'h7 : (mode == 3'h4) ? 4'h0 : 4'h3;
   assign mainPumpFast   = 4'hF;
   assign slipFactor     = (mode == 3'h3) ? 2'h2 : (mode == 3'h4) ? 2'h3 : 2'h1;
endmodule // host_model

/* File: sim/synth_power_lock_detect_sva.sv */
// Purpose: port checks of synth_power_lock_detect
// Assumes: lock timing checks apply with prescale off
// Notes:   goodCnt_r counts in-window main samples
`timescale 1ns/10ps
`include "synth_ctl_regs.vh"
module synth_power_lock_detect_sva (
   input wire core_clk, srst, chipEnable, main_loop_powerdown, aux_loop_powerdown,
   input wire auto_powerup_on_divider_write, mainDividerWrite, lock_detect_prescale_quarter,
   input wire [3:0] test_output_select,
   input wire [7:0] mainPhaseErrNs,
   input wire compEdge, fastAcqEnable, mainPowered, auxPowered, mainLocked, auxLocked,
   input wire test_lock_output, parallelResistorOn_r, acqActive_r, compEnable_r,
   input wire [`CP_STEP_W-1:0] mainPumpSteady, mainPumpFast, mainPumpCurrent_r
);
   reg [2:0] goodCnt_r;
   always @(posedge core_clk) begin
      if (srst)
         goodCnt_r <= 3'h0;
      else if (compEdge && !lock_detect_prescale_quarter)
         goodCnt_r <= (mainPhaseErrNs >= 8'h0A) ? 3'h0 : goodCnt_r + {2'h0, goodCnt_r != 3'h7};
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   pwr_off_a: assert property (!chipEnable |-> !mainPowered && !auxPowered && !test_lock_output)
      else $error("outputs alive with enable low");
   full_pwr_a: assert property (chipEnable && !main_loop_powerdown && !aux_loop_powerdown
      |-> mainPowered && auxPowered) else $error("not fully powered");
   aux_down_a: assert property (chipEnable && aux_loop_powerdown |-> !auxPowered)
      else $error("aux loop still powered");
   auto_pwr_a: assert property (chipEnable && auto_powerup_on_divider_write && mainDividerWrite
      ##1 chipEnable |-> mainPowered) else $error("no power-up on divider write");
   lock_entry_a: assert property ($rose(mainLocked) && $past(mainPowered)
      && !lock_detect_prescale_quarter |-> goodCnt_r >= 3'h5) else $error("early lock");
   lock_hold_a: assert property (mainLocked && compEdge && !lock_detect_prescale_quarter
      && mainPhaseErrNs <= 8'h14 ##1 mainPowered |-> mainLocked) else $error("lock lost");
   lock_drop_a: assert property (mainLocked && compEdge && !lock_detect_prescale_quarter
      && mainPhaseErrNs > 8'h14 |=> !mainLocked) else $error("lock kept");
   ld_forced_a: assert property (test_output_select == 4'h2 && !mainPowered
      |=> !test_lock_output) else $error("lock output not forced low");
   both_low_a: assert property (test_output_select == 4'h4 && !(mainLocked && auxLocked)
      |=> !test_lock_output) else $error("combined lock high");
   fast_on_a: assert property ($rose(acqActive_r) && fastAcqEnable
      |=> parallelResistorOn_r && mainPumpCurrent_r == mainPumpFast) else $error("fast not on");
   acq_end_a: assert property ($fell(acqActive_r)
      |=> !parallelResistorOn_r && mainPumpCurrent_r == mainPumpSteady) else $error("no release");
   comp_restore_a: assert property (!acqActive_r && !mainDividerWrite && mainPowered
      && compEdge |=> compEnable_r) else $error("compare edge dropped");
   cover property ($rose(mainLocked));
   cover property ($fell(acqActive_r));
   cover property (test_output_select == 4'h4 && test_lock_output);
endmodule // synth_power_lock_detect_sva
bind synth_power_lock_detect synth_power_lock_detect_sva chk_i (.*);

/* File: sim/tb_top.sv */
// Purpose: directed bench for synth_power_lock_detect
// Assumes: compEdge high every cycle, so each edge is one compare cycle
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`include "synth_ctl_regs.vh"
module tb_top;
   reg        core_clk = 1'b0, srst = 1'b1, chipEnable = 1'b0, compEdge = 1'b0;
   reg        main_loop_powerdown = 1'b0, aux_loop_powerdown = 1'b0, mainDividerWrite = 1'b0;
   reg        auto_powerup_on_divider_write = 1'b0, lock_detect_prescale_quarter = 1'b0;
   reg  [3:0] test_output_select = 4'h0;
   reg  [7:0] mainPhaseErrNs = 8'hFF, auxPhaseErrNs = 8'hFF;
   reg  [2:0] mode = 3'h0;
   wire       slip_reduction, fastAcqEnable, mainPowered, auxPowered, mainLocked, auxLocked;
   wire       test_lock_output, parallelResistorOn_r, compEnable_r, acqActive_r;
   wire [15:0] acqTimeout;
   wire [`CP_STEP_W-1:0] mainPumpSteady, mainPumpFast, mainPumpCurrent_r;
   wire [`CSR_FACTOR_W-1:0] slipFactor;
   integer err_count = 0, comparisons = 0, tn = 0, i, n;
   always #5 core_clk = ~core_clk;
   synth_power_lock_detect dut (.*);
   host_model host (.*);
   task tick(input integer k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task chk(input [15:0] g, input [15:0] e);
      comparisons = comparisons + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task feed(input [7:0] m, input [7:0] a, input integer k);
      mainPhaseErrNs = m;
      auxPhaseErrNs = a;
      tick(k);
   endtask
   task endt;
      tn = tn + 1;
      $display("test %0d done", tn);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      tick(3);
      srst = 1'b0;
      compEdge = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         {chipEnable, main_loop_powerdown, aux_loop_powerdown} = i[2:0];
         tick(1);
         chk({mainPowered, auxPowered}, {i[2] & ~i[1], i[2] & ~i[0]});
      end
      auto_powerup_on_divider_write = 1'b1;
      mainDividerWrite = 1'b1;
      tick(1);
      mainDividerWrite = 1'b0;
      tick(1);
      chk({mainPowered, auxPowered}, 2'h2);
      {main_loop_powerdown, aux_loop_powerdown, auto_powerup_on_divider_write} = 3'h0;
      endt;
      feed(8'h09, 8'h0E, 4);
      chk({mainLocked, auxLocked}, 2'h0);
      feed(8'h0A, 8'h0F, 1);
      feed(8'h09, 8'h0E, 4);
      chk({mainLocked, auxLocked}, 2'h0);
      feed(8'h09, 8'h0E, 2);
      chk({mainLocked, auxLocked}, 2'h3);
      feed(8'h14, 8'h1E, 3);
      chk({mainLocked, auxLocked}, 2'h3);
      for (n = 2; n < 6; n = n + 1) begin
         test_output_select = n[3:0];
         tick(2);
         chk(test_lock_output, n < 5);
      end
      test_output_select = 4'h4;
      feed(8'h15, 8'h1E, 3);
      chk({mainLocked, auxLocked, test_lock_output}, 3'h2);
      feed(8'h09, 8'h0E, 6);
      test_output_select = 4'h2;
      main_loop_powerdown = 1'b1;
      tick(2);
      chk({mainLocked, test_lock_output}, 2'h0);
      main_loop_powerdown = 1'b0;
      endt;
      feed(8'hFF, 8'hFF, 2);
      lock_detect_prescale_quarter = 1'b1;
      feed(8'h09, 8'h0E, 8);
      chk(mainLocked, 1'b0);
      feed(8'h09, 8'h0E, 16);
      chk(mainLocked, 1'b1);
      lock_detect_prescale_quarter = 1'b0;
      endt;
      for (i = 1; i < 5; i = i + 1) begin
         mode = i[2:0];
         tick(1);
         mainDividerWrite = 1'b1;
         tick(1);
         mainDividerWrite = 1'b0;
         chk(acqActive_r, 1'b1);
         tick(2);
         chk({parallelResistorOn_r, mainPumpCurrent_r}, {i == 2, mainPumpFast});
         n = 0;
         repeat (8) begin
            tick(1);
            n = n + compEnable_r;
         end
         // eight compare cycles pass 4, 8, 2 or 0 edges at 1/2, none, 1/4, 1/16
         chk(n, (i == 1) ? 16'h0004 : (i == 2) ? 16'h0008 : (i == 3) ? 16'h0002 : 16'h0000);
         for (n = 0; n < 100 && acqActive_r !== 1'b0; n = n + 1) tick(1);
         if (acqActive_r !== 1'b0) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t acquisition hang got %h exp %h", $time, acqActive_r, 1'b0);
            i = 5;
         end else begin
            tick(2);
            chk({parallelResistorOn_r, mainPumpCurrent_r}, {1'b0, mainPumpSteady});
            n = 0;
            repeat (8) begin
               tick(1);
               n = n + compEnable_r;
            end
            chk(n, 8);
            endt;
         end
      end
      complete_run;
   end
endmodule // tb_top
